// >>> tmpc_power_cutoff.sv
// Transport-mode power cutoff controller top level.
`timescale 1ns/1ps
module tmpc_power_cutoff
    import tmpc_pkg::*;
#(
    parameter logic [47:0] CYC_72H = TMPC_CYC_72H,
    parameter logic [47:0] CYC_5S = TMPC_CYC_5S,
    parameter logic [47:0] CYC_3S = TMPC_CYC_3S,
    parameter logic [47:0] CYC_2S = TMPC_CYC_2S
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic ignition_run_sense,
    input wire logic batt_present,
    output logic load_out,
    output logic transport_sleep,
    output logic normal_mode
);

    // ------------------------------------------------------------
    // Input synchronisers and edge detection.
    // ------------------------------------------------------------
    logic [1:0] ign_sync_r;
    logic [1:0] ign_sync_nxt;
    logic ign_d_r;
    logic [1:0] bat_sync_r;
    logic [1:0] bat_sync_nxt;
    logic ign;
    logic ign_rise;
    logic ign_fall;
    logic bat_ok;

    // Shift pins through two flops before any logic looks at them.
    always_comb
    begin
        ign_sync_nxt = {ign_sync_r[0], ignition_run_sense};
        bat_sync_nxt = {bat_sync_r[0], batt_present};
    end

    // Register the synchronisers and the delayed ignition level.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ign_sync_r <= TMPC_SYNC_RST;
            // Reset means supply applied, so no false outage after reset.
            bat_sync_r <= TMPC_BAT_SYNC_RST;
            ign_d_r <= 1'b0;
        end
        else if (clk_en)
        begin
            ign_sync_r <= ign_sync_nxt;
            bat_sync_r <= bat_sync_nxt;
            ign_d_r <= ign_sync_r[1];
        end
    end

    // Edges come from the second stage against its delayed copy.
    assign ign = ign_sync_r[1];
    assign ign_rise = ign & ~ign_d_r;
    assign ign_fall = ~ign & ign_d_r;
    assign bat_ok = bat_sync_r[1];

    // ------------------------------------------------------------
    // Interval timers.
    // ------------------------------------------------------------
    tmpc_tmr_if off_tif ();
    tmpc_tmr_if win_tif ();
    tmpc_tmr_if hold_tif ();
    tmpc_tmr_if sup_tif ();

    tmpc_interval_timer #(.LIMIT(CYC_72H)) u_off_tmr
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .tif(off_tif)
    );

    tmpc_interval_timer #(.LIMIT(CYC_5S)) u_win_tmr
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .tif(win_tif)
    );

    tmpc_interval_timer #(.LIMIT(CYC_2S)) u_hold_tmr
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .tif(hold_tif)
    );

    tmpc_interval_timer #(.LIMIT(CYC_3S)) u_sup_tmr
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .tif(sup_tif)
    );

    // ------------------------------------------------------------
    // Toggle pattern tracking.
    // ------------------------------------------------------------
    tmpc_state_t state_r;
    tmpc_state_t state_nxt;
    logic [2:0] rises_r;
    logic [2:0] rises_nxt;
    logic hold_arm_r;
    logic hold_arm_nxt;
    logic win_start;
    logic pat_sleep;
    logic pat_normal;
    logic in_transport;

    assign in_transport = (state_r != TMPC_ST_NORMAL);

    // Count rises inside a 5 s window opened by the first rise.
    always_comb
    begin
        rises_nxt = rises_r;
        hold_arm_nxt = hold_arm_r;
        win_start = 1'b0;
        pat_sleep = 1'b0;
        if (win_tif.hit && !ign_rise)
        begin
            rises_nxt = 3'h0; // Window lapsed, pattern forgotten.
        end
        if (ign_rise)
        begin
            if (rises_r == 3'h0 || win_tif.hit)
            begin
                rises_nxt = 3'h1;
                win_start = 1'b1;
            end
            else if (rises_r != TMPC_RISES_MAX)
            begin
                rises_nxt = rises_r + 3'h1;
            end
            if (rises_nxt == TMPC_RISES_NORMAL)
            begin
                hold_arm_nxt = 1'b1;
            end
        end
        if (ign_fall)
        begin
            hold_arm_nxt = 1'b0; // Third high not held long enough.
            if (rises_r >= TMPC_RISES_SLEEP && !win_tif.hit)
            begin
                pat_sleep = 1'b1;
                rises_nxt = 3'h0;
            end
        end
        if (!in_transport)
        begin
            rises_nxt = 3'h0;
            hold_arm_nxt = 1'b0;
        end
    end

    // The third high must stay up for the full hold interval.
    assign pat_normal = hold_arm_r & hold_tif.hit & ign;

    // Drive the timer controls.
    assign win_tif.restart = win_start;
    assign win_tif.run = (rises_r != 3'h0);
    assign hold_tif.restart = ign_rise;
    assign hold_tif.run = hold_arm_r & ign;
    assign off_tif.restart = ign | (state_r != TMPC_ST_FIRST);
    assign off_tif.run = ~ign;
    assign sup_tif.restart = bat_ok;
    assign sup_tif.run = ~bat_ok;

    // Register the pattern state.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rises_r <= 3'h0;
            hold_arm_r <= 1'b0;
        end
        else if (clk_en)
        begin
            rises_r <= rises_nxt;
            hold_arm_r <= hold_arm_nxt;
        end
    end

    // ------------------------------------------------------------
    // Mode state machine and outputs.
    // ------------------------------------------------------------
    logic load_nxt;
    logic sleep_nxt;
    logic normal_nxt;

    // Pick the next mode; supply loss overrides everything.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            TMPC_ST_FIRST:
            begin
                if (pat_normal)
                begin
                    state_nxt = TMPC_ST_NORMAL;
                end
                else if (off_tif.hit || pat_sleep)
                begin
                    state_nxt = TMPC_ST_SLEEP;
                end
            end
            TMPC_ST_SLEEP:
            begin
                if (ign)
                begin
                    state_nxt = TMPC_ST_AWAKE;
                end
            end
            TMPC_ST_AWAKE:
            begin
                if (pat_normal)
                begin
                    state_nxt = TMPC_ST_NORMAL;
                end
                else if (ign_fall || pat_sleep)
                begin
                    state_nxt = TMPC_ST_SLEEP;
                end
            end
            TMPC_ST_NORMAL:
            begin
                state_nxt = TMPC_ST_NORMAL;
            end
            default:
            begin
                state_nxt = TMPC_ST_FIRST;
            end
        endcase
        if (sup_tif.hit)
        begin
            state_nxt = TMPC_ST_FIRST;
        end
        load_nxt = (state_nxt != TMPC_ST_SLEEP);
        sleep_nxt = (state_nxt == TMPC_ST_SLEEP);
        normal_nxt = (state_nxt == TMPC_ST_NORMAL);
    end

    // Register mode and outputs; power-up starts in transport mode.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= TMPC_ST_FIRST;
            load_out <= 1'b1;
            transport_sleep <= 1'b0;
            normal_mode <= 1'b0;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            load_out <= load_nxt;
            transport_sleep <= sleep_nxt;
            normal_mode <= normal_nxt;
        end
    end

endmodule

// >>> tmpc_pkg.sv
// Constants for the transport-mode power cutoff controller.
package tmpc_pkg;

    // ------------------------------------------------------------
    // Clock rate and counter width.
    // ------------------------------------------------------------
    localparam int TMPC_CW = 48;
    localparam logic [47:0] TMPC_CLK_HZ = 48'h000002625A00;
    localparam logic [47:0] TMPC_SEC_PER_H = 48'h000000000E10;

    // ------------------------------------------------------------
    // Interval figures in their own units.
    // ------------------------------------------------------------
    localparam logic [47:0] TMPC_OFF_WAIT_H = 48'h000000000048;
    localparam logic [47:0] TMPC_WINDOW_S = 48'h000000000005;
    localparam logic [47:0] TMPC_HOLD_S = 48'h000000000002;
    localparam logic [47:0] TMPC_SUPPLY_S = 48'h000000000003;

    // ------------------------------------------------------------
    // Derived cycle counts at the core clock rate.
    // ------------------------------------------------------------
    localparam logic [47:0] TMPC_CYC_72H =
        TMPC_OFF_WAIT_H * TMPC_SEC_PER_H * TMPC_CLK_HZ;
    localparam logic [47:0] TMPC_CYC_5S = TMPC_WINDOW_S * TMPC_CLK_HZ;
    localparam logic [47:0] TMPC_CYC_2S = TMPC_HOLD_S * TMPC_CLK_HZ;
    localparam logic [47:0] TMPC_CYC_3S = TMPC_SUPPLY_S * TMPC_CLK_HZ;

    // ------------------------------------------------------------
    // Pattern counts and reset values.
    // ------------------------------------------------------------
    localparam logic [2:0] TMPC_RISES_NORMAL = 3'h3;
    localparam logic [2:0] TMPC_RISES_SLEEP = 3'h5;
    localparam logic [2:0] TMPC_RISES_MAX = 3'h7;
    localparam logic [1:0] TMPC_SYNC_RST = 2'h0;
    localparam logic [1:0] TMPC_BAT_SYNC_RST = 2'h3;

    // ------------------------------------------------------------
    // Controller states.
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        TMPC_ST_FIRST = 2'b00,
        TMPC_ST_SLEEP = 2'b01,
        TMPC_ST_AWAKE = 2'b10,
        TMPC_ST_NORMAL = 2'b11
    } tmpc_state_t;

endpackage

// >>> tmpc_tmr_if.sv
// Interface joining the controller to one interval timer.
`timescale 1ns/1ps
interface tmpc_tmr_if;
    logic restart;
    logic run;
    logic hit;

    modport ctl
    (
        output restart,
        output run,
        input hit
    );
    modport tmr
    (
        input restart,
        input run,
        output hit
    );
endinterface

// >>> tmpc_interval_timer.sv
// Saturating interval timer with restart and run controls.
`timescale 1ns/1ps
module tmpc_interval_timer
    import tmpc_pkg::*;
#(
    parameter logic [47:0] LIMIT = TMPC_CYC_2S
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    tmpc_tmr_if.tmr tif
);

    logic [TMPC_CW-1:0] cnt_r;
    logic [TMPC_CW-1:0] cnt_nxt;
    logic hit_r;
    logic hit_nxt;

    // --------------------------------------------------------
    // Next count: restart wins, counting stops at the limit.
    // --------------------------------------------------------
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (tif.restart)
        begin
            cnt_nxt = '0;
        end
        else if (tif.run && !hit_r)
        begin
            cnt_nxt = cnt_r + 48'h000000000001;
        end
        hit_nxt = (cnt_nxt >= LIMIT);
    end

    // Register the count and the expiry flag.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_r <= '0;
            hit_r <= 1'b0;
        end
        else if (clk_en)
        begin
            cnt_r <= cnt_nxt;
            hit_r <= hit_nxt;
        end
    end

    assign tif.hit = hit_r;

endmodule

// >>> tmpc_power_cutoff_asserts.sv
// Concurrent checks on the power cutoff controller ports.
`timescale 1ns/1ps
module tmpc_power_cutoff_asserts
    import tmpc_pkg::*;
#(
    parameter logic [143:0] CYC_LIM =
        {TMPC_CYC_72H, TMPC_CYC_3S, TMPC_CYC_2S}
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic ignition_run_sense,
    input wire logic batt_present,
    input wire logic load_out,
    input wire logic transport_sleep,
    input wire logic normal_mode
);
    // Interval limits unpacked from the one bound parameter.
    localparam logic [47:0] CYC_72H = CYC_LIM[143:96];
    localparam logic [47:0] CYC_3S = CYC_LIM[95:48];
    localparam logic [47:0] CYC_2S = CYC_LIM[47:0];

    logic [47:0] hi_r, hi_nxt, lo_r, lo_nxt, bl_r, bl_nxt;
    logic slp_r, woke_r, woke_nxt;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // -----------------------------------------------------------
    // Helper logic
    // -----------------------------------------------------------
    // Run lengths at the pins, and a flag for a wake from sleep.
    always_comb
    begin
        hi_nxt = ignition_run_sense ? hi_r + 48'h1 : 48'h0;
        lo_nxt = (ignition_run_sense || !batt_present) ? 48'h0 : lo_r + 48'h1;
        bl_nxt = batt_present ? 48'h0 : bl_r + 48'h1;
        woke_nxt = !transport_sleep && !normal_mode &&
            ((slp_r && batt_present) || woke_r);
    end

    // Registers the helper state; it freezes with the design's timers.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hi_r <= 48'h0;
            lo_r <= 48'h0;
            bl_r <= 48'h0;
            slp_r <= 1'b0;
            woke_r <= 1'b0;
        end
        else if (clk_en)
        begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            bl_r <= bl_nxt;
            slp_r <= transport_sleep;
            woke_r <= woke_nxt;
        end
    end

    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    sequence s_batt_steady;
        batt_present [*5];
    endsequence
    sequence s_woke_fall;
        woke_r && $fell(ignition_run_sense);
    endsequence

    a_sleep_load_open: assert property
        (transport_sleep |-> !load_out && !normal_mode)
        else $error("load closed while asleep");
    a_normal_load_high: assert property
        (normal_mode |-> load_out && !transport_sleep)
        else $error("load open in normal mode");
    a_wake_on_high: assert property
        (transport_sleep && ignition_run_sense |-> ##[1:5] load_out)
        else $error("no wake on ignition high");
    a_fall_to_sleep: assert property
        (s_woke_fall |-> ##[1:6] transport_sleep)
        else $error("no sleep after ignition fall");
    a_normal_held: assert property
        ($rose(normal_mode) |-> $past(hi_r, 4) >= CYC_2S - 48'h4)
        else $error("normal mode without a full hold");
    a_first_timeout: assert property
        (lo_r == CYC_72H + 48'h8 && !normal_mode |-> transport_sleep)
        else $error("no sleep after long ignition low");
    a_supply_restart: assert property
        (bl_r == CYC_3S + 48'h6 |-> load_out && !transport_sleep &&
            !normal_mode)
        else $error("no restart after supply loss");
    a_normal_sticky: assert property
        (s_batt_steady ##0 normal_mode |=> normal_mode)
        else $error("normal mode lost with supply present");
endmodule

bind tmpc_power_cutoff tmpc_power_cutoff_asserts #(
    .CYC_LIM({CYC_72H, CYC_3S, CYC_2S})) u_chk
(
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .ignition_run_sense(ignition_run_sense),
    .batt_present(batt_present),
    .load_out(load_out),
    .transport_sleep(transport_sleep),
    .normal_mode(normal_mode)
);

// >>> tmpc_ign_model.sv
// Behavioural ignition switch and battery supply for the bench.
`timescale 1ns/1ps
module tmpc_ign_model
(
    input wire logic core_clk,
    output logic ign,
    output logic batt
);
    // Key starts off and the battery starts connected.
    initial
    begin
        ign = 1'b0;
        batt = 1'b1;
    end

    // Sets the key to one level and keeps it there n cycles.
    task automatic hold(input logic lvl, input int n);
        @(posedge core_clk);
        ign <= lvl;
        repeat (n - 1) @(posedge core_clk);
    endtask

    // Turns the key on and off k times, w cycles at each level.
    task automatic pulses(input int k, input int w);
        repeat (k)
        begin
            hold(1'b1, w);
            hold(1'b0, w);
        end
    endtask

    // Disconnects the battery for n cycles, then reconnects it.
    task automatic cut(input int n);
        @(posedge core_clk);
        batt <= 1'b0;
        repeat (n) @(posedge core_clk);
        batt <= 1'b1;
    endtask
endmodule

// >>> tmpc_power_cutoff_tb.sv
// Self-checking bench for the power cutoff controller.
`timescale 1ns/1ps
module tmpc_power_cutoff_tb;
    localparam int L_72H = 200;
    localparam int L_2S = 20;
    localparam logic [2:0] ST_FIRST = 3'h4;
    localparam logic [2:0] ST_SLEEP = 3'h2;
    localparam logic [2:0] ST_NORM = 3'h5;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic ign;
    logic batt;
    logic load_out;
    logic transport_sleep;
    logic normal_mode;
    logic [2:0] outs;
    int mismatches = 0;
    int cmp_count = 0;

    assign outs = {load_out, transport_sleep, normal_mode};

    // Free-running core clock.
    always #12.5 core_clk = ~core_clk;

    tmpc_ign_model u_sw
    (
        .core_clk(core_clk),
        .ign(ign),
        .batt(batt)
    );

    tmpc_power_cutoff #(.CYC_72H(48'h0000000000C8), .CYC_5S(48'h000000000032),
        .CYC_3S(48'h00000000001E), .CYC_2S(48'h000000000014)) dut
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .ignition_run_sense(ign),
        .batt_present(batt),
        .load_out(load_out),
        .transport_sleep(transport_sleep),
        .normal_mode(normal_mode)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compares the three mode outputs with an expected pattern.
    task automatic check(input logic [2:0] exp);
        #1;
        cmp_count++;
        if (outs !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, outs, exp);
        end
    endtask

    // Waits at most n cycles for a pattern; a miss ends the run.
    task automatic settle(input logic [2:0] exp, input int n);
        int i;
        #1;
        i = 0;
        while (i < n && outs !== exp)
        begin
            @(posedge core_clk);
            #1;
            i++;
        end
        check(exp);
        if (outs !== exp)
        begin
            final_report();
        end
    endtask

    // Power-up state, a ten-cycle freeze, then sleep after a long
    // ignition-off spell; the freeze must delay the timeout.
    task automatic t_power_up();
        @(posedge core_clk);
        check(ST_FIRST);
        @(posedge core_clk);
        clk_en <= 1'b0;
        repeat (10) @(posedge core_clk);
        clk_en <= 1'b1;
        check(ST_FIRST);
        repeat (L_72H - 8) @(posedge core_clk);
        check(ST_FIRST);
        settle(ST_SLEEP, 12);
        $display("power-up timeout test done");
    endtask

    // Wake on ignition high, back to sleep on the fall.
    task automatic t_wake_fall();
        u_sw.hold(1'b1, 1);
        settle(ST_FIRST, 6);
        u_sw.hold(1'b1, 10);
        u_sw.hold(1'b0, 1);
        settle(ST_SLEEP, 6);
        u_sw.cut(40);
        settle(ST_FIRST, 10);
        $display("wake and fall test done");
    endtask

    // Four toggles keep it awake, five then off put it to sleep.
    task automatic t_five_toggles();
        u_sw.pulses(4, 4);
        repeat (10) @(posedge core_clk);
        check(ST_FIRST);
        u_sw.hold(1'b0, 60);
        u_sw.pulses(5, 4);
        settle(ST_SLEEP, 8);
        u_sw.cut(40);
        settle(ST_FIRST, 10);
        $display("five toggle test done");
    endtask

    // A short third hold is refused, a full one enters normal mode.
    task automatic t_normal_entry();
        u_sw.pulses(2, 4);
        u_sw.hold(1'b1, 14);
        u_sw.hold(1'b0, 10);
        check(ST_FIRST);
        u_sw.hold(1'b0, 60);
        u_sw.pulses(2, 4);
        u_sw.hold(1'b1, L_2S - 6);
        check(ST_FIRST);
        settle(ST_NORM, 12);
        $display("normal entry test done");
    endtask

    // Normal mode ignores the key and a short outage only.
    task automatic t_normal_stays();
        u_sw.hold(1'b0, 1);
        u_sw.pulses(5, 4);
        check(ST_NORM);
        u_sw.cut(20);
        repeat (10) @(posedge core_clk);
        check(ST_NORM);
        u_sw.cut(40);
        settle(ST_FIRST, 10);
        $display("normal hold test done");
    endtask

    // Main sequence: reset for four cycles, then the scenarios.
    initial
    begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        t_power_up();
        t_wake_fall();
        t_five_toggles();
        t_normal_entry();
        t_normal_stays();
        final_report();
    end
endmodule
